// ===== logic/pamux_pin_sel.sv
// one pin's priority selector: first enabled peripheral wins over latch
// assumes sources are listed highest priority first in bit 0 upward
`timescale 1ns/100ps
module pamux_pin_sel #(
   parameter int N_SRC = 2
) (
   // peripheral sources, index 0 highest
   input  wire logic [N_SRC-1:0] src_en,
   input  wire logic [N_SRC-1:0] src_val,
   // port latch fallback
   input  wire logic             latch_val,
   input  wire logic             latch_oe,
   // resolved pin
   output logic                  pin_val,
   output logic                  pin_oe,
   output logic [N_SRC-1:0]      grant
);
   // elaboration check: a selector with no source has nothing to rank
   if (N_SRC < 1) begin : g_bad_src
      $error("pamux_pin_sel needs at least one source");
   end

   logic [N_SRC-1:0] taken;
   // ripple priority: a source wins only if none above it is enabled
   generate
      for (genvar i = 0; i < N_SRC; i++) begin : g_pri
         if (i == 0) begin : g_top
            assign grant[i] = src_en[i];
            assign taken[i] = src_en[i];
         end else begin : g_low
            assign grant[i] = src_en[i] & ~taken[i-1];
            assign taken[i] = src_en[i] | taken[i-1];
         end
      end
   endgenerate

   wire any_periph = taken[N_SRC-1];
   wire periph_val = |(grant & src_val);
   assign pin_val = any_periph ? periph_val : latch_val;
   assign pin_oe  = any_periph | latch_oe;
endmodule : pamux_pin_sel

// ===== logic/pamux_pkg.sv
// package for the port a output priority multiplexer
// assumes one synchronous clock domain; no software-visible registers
package pamux_pkg;
   localparam int PAMUX_PINS      = 8;
   // pin positions that carry peripheral outputs
   localparam int PAMUX_PIN_OPAMP = 1;
   localparam int PAMUX_PIN_DAC   = 2;
   localparam int PAMUX_PIN_CMP1  = 4;
   localparam int PAMUX_PIN_CMP2  = 5;
   localparam int PAMUX_PIN_CKOUT = 6;
   // reset values of registered pin outputs
   localparam logic [7:0] PAMUX_RST_OUT = 8'h00;
   localparam logic [7:0] PAMUX_RST_OE  = 8'h00;
   localparam logic [7:0] PAMUX_RST_AN  = 8'h00;
   // source codes of the pin winner
   typedef enum logic [2:0] {
      PAMUX_SRC_LATCH = 3'h0,
      PAMUX_SRC_OPAMP = 3'h1,
      PAMUX_SRC_DAC   = 3'h3,
      PAMUX_SRC_CMP1  = 3'h2,
      PAMUX_SRC_CMP2  = 3'h6,
      PAMUX_SRC_CKOUT = 3'h7
   } pamux_src_e;
endpackage : pamux_pkg

// ===== logic/pamux_top.sv
// port a output priority multiplexer for eight pins
// assumes all inputs synchronous to ref_clk; rst synchronous, active high
`timescale 1ns/100ps
module pamux_top
   import pamux_pkg::*;
#(
   parameter int PINS = PAMUX_PINS
) (
   // clock and reset
   input  wire logic            ref_clk,
   input  wire logic            rst,
   // port latch and direction (1 = drive)
   input  wire logic [PINS-1:0] port_a_latch,
   input  wire logic [PINS-1:0] port_a_drive,
   // analog select per pin
   input  wire logic [PINS-1:0] analog_select_regs,
   // peripheral outputs and their enables
   input  wire logic            opamp_one_output,
   input  wire logic            opamp_one_en,
   input  wire logic            dac_one_output,
   input  wire logic            dac_one_en,
   input  wire logic            comparator_one_output,
   input  wire logic            comparator_one_en,
   input  wire logic            comparator_two_output,
   input  wire logic            comparator_two_en,
   input  wire logic            clock_out_signal,
   input  wire logic            clock_out_en,
   // pin read-back from the pads
   input  wire logic [PINS-1:0] port_a_pins_in,
   // pad drive
   output logic [PINS-1:0]      port_a_pins_out,
   output logic [PINS-1:0]      port_a_pins_oe,
   // analog path enable and digital input read
   output logic [PINS-1:0]      analog_in_en,
   output logic [PINS-1:0]      port_a_pins_rd,
   // current winner of pin 6, the only three-way pin
   output pamux_src_e           pin6_src
);
   // elaboration check: the pin map below is fixed to eight pins
   if (PINS != PAMUX_PINS) begin : g_bad_pins
      $error("pamux_top serves eight pins only");
   end

   // ==========================================================
   // per-pin resolution
   logic [PINS-1:0] val_c;
   logic [PINS-1:0] oe_c;
   logic [1:0]      p6_grant;

   // latch-only pins 0, 3, 7
   generate
      for (genvar i = 0; i < PINS; i++) begin : g_latch_only
         if (i != PAMUX_PIN_OPAMP && i != PAMUX_PIN_DAC &&
             i != PAMUX_PIN_CMP1 && i != PAMUX_PIN_CMP2 &&
             i != PAMUX_PIN_CKOUT) begin : g_l
            assign val_c[i] = port_a_latch[i];
            assign oe_c[i]  = port_a_drive[i];
         end
      end
   endgenerate

   // analog select is not an input here: outputs resolve regardless
   pamux_pin_sel #(.N_SRC(1)) u_pin1 (
      .src_en    (opamp_one_en),
      .src_val   (opamp_one_output),
      .latch_val (port_a_latch[PAMUX_PIN_OPAMP]),
      .latch_oe  (port_a_drive[PAMUX_PIN_OPAMP]),
      .pin_val   (val_c[PAMUX_PIN_OPAMP]),
      .pin_oe    (oe_c[PAMUX_PIN_OPAMP]),
      .grant     ()
   );
   pamux_pin_sel #(.N_SRC(1)) u_pin2 (
      .src_en    (dac_one_en),
      .src_val   (dac_one_output),
      .latch_val (port_a_latch[PAMUX_PIN_DAC]),
      .latch_oe  (port_a_drive[PAMUX_PIN_DAC]),
      .pin_val   (val_c[PAMUX_PIN_DAC]),
      .pin_oe    (oe_c[PAMUX_PIN_DAC]),
      .grant     ()
   );
   pamux_pin_sel #(.N_SRC(1)) u_pin4 (
      .src_en    (comparator_one_en),
      .src_val   (comparator_one_output),
      .latch_val (port_a_latch[PAMUX_PIN_CMP1]),
      .latch_oe  (port_a_drive[PAMUX_PIN_CMP1]),
      .pin_val   (val_c[PAMUX_PIN_CMP1]),
      .pin_oe    (oe_c[PAMUX_PIN_CMP1]),
      .grant     ()
   );
   pamux_pin_sel #(.N_SRC(1)) u_pin5 (
      .src_en    (comparator_two_en),
      .src_val   (comparator_two_output),
      .latch_val (port_a_latch[PAMUX_PIN_CMP2]),
      .latch_oe  (port_a_drive[PAMUX_PIN_CMP2]),
      .pin_val   (val_c[PAMUX_PIN_CMP2]),
      .pin_oe    (oe_c[PAMUX_PIN_CMP2]),
      .grant     ()
   );
   // clock out outranks comparator two, which outranks the latch
   pamux_pin_sel #(.N_SRC(2)) u_pin6 (
      .src_en    ({comparator_two_en, clock_out_en}),
      .src_val   ({comparator_two_output, clock_out_signal}),
      .latch_val (port_a_latch[PAMUX_PIN_CKOUT]),
      .latch_oe  (port_a_drive[PAMUX_PIN_CKOUT]),
      .pin_val   (val_c[PAMUX_PIN_CKOUT]),
      .pin_oe    (oe_c[PAMUX_PIN_CKOUT]),
      .grant     (p6_grant)
   );

   // pin 6 winner as a source code; grant is one-hot or zero
   function automatic pamux_src_e pin6_code(input logic [1:0] g);
      pamux_src_e code;
      code = PAMUX_SRC_LATCH;
      if (g[0]) begin
         code = PAMUX_SRC_CKOUT;
      end else if (g[1]) begin
         code = PAMUX_SRC_CMP2;
      end
      return code;
   endfunction : pin6_code

   wire pamux_src_e p6_src_c = pin6_code(p6_grant);

   // ==========================================================
   // input side: analog pins read digital zero
   wire [PINS-1:0] an_en_c = analog_select_regs;
   wire [PINS-1:0] rd_c    = port_a_pins_in & ~analog_select_regs;

   // ==========================================================
   // registered outputs; one cycle of latency keeps pad drive glitch-free
   // including clock_out, which then toggles at most at half ref_clk
   logic [PINS-1:0] out_r;
   logic [PINS-1:0] oe_r;
   logic [PINS-1:0] an_r;
   logic [PINS-1:0] rd_r;
   pamux_src_e      src_r;

   wire [PINS-1:0]  out_nxt = val_c;
   wire [PINS-1:0]  oe_nxt  = oe_c;
   wire [PINS-1:0]  an_nxt  = an_en_c;
   wire [PINS-1:0]  rd_nxt  = rd_c;
   wire pamux_src_e src_nxt = p6_src_c;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         out_r <= PAMUX_RST_OUT;
         oe_r  <= PAMUX_RST_OE;
         an_r  <= PAMUX_RST_AN;
         rd_r  <= '0;
         src_r <= PAMUX_SRC_LATCH;
      end else begin
         out_r <= out_nxt;
         oe_r  <= oe_nxt;
         an_r  <= an_nxt;
         rd_r  <= rd_nxt;
         src_r <= src_nxt;
      end
   end

   assign port_a_pins_out = out_r;
   assign port_a_pins_oe  = oe_r;
   assign analog_in_en    = an_r;
   assign port_a_pins_rd  = rd_r;
   assign pin6_src        = src_r;
endmodule : pamux_top

// ===== sim/pamux_far.sv
// far side: peripheral sources and the pads of port a
// assumes sources move after the falling edge; pads have no pull
`timescale 1ns/100ps
module pamux_far (
   input  wire logic       ref_clk,
   input  wire logic [7:0] pins_out, pins_oe,
   output logic [4:0]      src_val,
   output logic [7:0]      pins_in
);
   logic [7:0] cnt_r = 8'h00;
   always @(negedge ref_clk) cnt_r <= cnt_r + 8'h01;
   // undriven pads show the free-running count, whose upper bits change only slowly
   assign pins_in = (pins_out & pins_oe) | (cnt_r & ~pins_oe);
   assign src_val = cnt_r[4:0];
endmodule : pamux_far

// ===== sim/pamux_monitor.sv
// checker on the pin outputs of pamux_top
// assumes one clock; outputs follow inputs one edge later
`timescale 1ns/100ps
module pamux_monitor
   import pamux_pkg::*;
(
   // clock, reset and inputs
   input wire logic       ref_clk, rst,
   input wire logic [7:0] port_a_latch, port_a_drive, analog_select_regs,
   input wire logic       opamp_one_output, opamp_one_en, dac_one_output,
   input wire logic       dac_one_en, comparator_one_output,
   input wire logic       comparator_one_en, comparator_two_output,
   input wire logic       comparator_two_en, clock_out_signal, clock_out_en,
   // outputs
   input wire logic [7:0] port_a_pins_out, port_a_pins_oe, analog_in_en,
   input wire pamux_src_e pin6_src
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   a_pin1_opamp: assert property (opamp_one_en |=>
      port_a_pins_oe[1] && port_a_pins_out[1] == $past(opamp_one_output))
      else $error("pin1 not driven by opamp");
   a_pin2_dac: assert property (dac_one_en |=>
      port_a_pins_oe[2] && port_a_pins_out[2] == $past(dac_one_output))
      else $error("pin2 not driven by dac");
   a_pin4_cmp1: assert property (comparator_one_en |=>
      port_a_pins_oe[4] && port_a_pins_out[4] == $past(comparator_one_output))
      else $error("pin4 not driven by comparator one");
   a_pin5_cmp2: assert property (comparator_two_en |=>
      port_a_pins_oe[5] && port_a_pins_out[5] == $past(comparator_two_output))
      else $error("pin5 not driven by comparator two");
   a_pin6_clock_out_signal: assert property (clock_out_en |=>
      pin6_src == PAMUX_SRC_CKOUT && port_a_pins_oe[6] &&
      port_a_pins_out[6] == $past(clock_out_signal))
      else $error("pin6 not driven by clock out");
   a_pin6_cmp2: assert property (!clock_out_en && comparator_two_en |=>
      pin6_src == PAMUX_SRC_CMP2 && port_a_pins_oe[6] &&
      port_a_pins_out[6] == $past(comparator_two_output))
      else $error("pin6 not driven by comparator two");
   a_pin6_latch: assert property (!clock_out_en && !comparator_two_en |=>
      pin6_src == PAMUX_SRC_LATCH &&
      port_a_pins_out[6] == $past(port_a_latch[6]) &&
      port_a_pins_oe[6] == $past(port_a_drive[6]))
      else $error("pin6 not driven by latch");
   a_latch_only: assert property (1'b1 |=>
      (((port_a_pins_out ^ $past(port_a_latch)) |
        (port_a_pins_oe ^ $past(port_a_drive))) & 8'h89) == 8'h00)
      else $error("latch-only pin differs from latch");
   a_analog_sel: assert property (1'b1 |=>
      analog_in_en == $past(analog_select_regs))
      else $error("analog path not following select");
endmodule : pamux_monitor
bind pamux_top pamux_monitor i_pamux_monitor (.*);

// ===== sim/pamux_tb.sv
// self-checking bench for the port a output priority mux
// assumes pamux_far supplies sources and pads
`timescale 1ns/100ps
module pamux_tb;
   import pamux_pkg::*;
   logic ref_clk = 1'b0, rst = 1'b1;
   logic [7:0] lat = 8'h00, drv = 8'h00, an = 8'h00, pin_in, p_out, p_oe;
   logic [7:0] a_en, p_rd, e_out, e_oe, e_rd;
   logic [4:0] en = 5'h00, sv;
   pamux_src_e src, e_src;
   int n_fail = 0, comparisons = 0;
   pamux_top i_pamux_top (.ref_clk, .rst, .port_a_latch(lat),
      .port_a_drive(drv), .analog_select_regs(an), .opamp_one_output(sv[0]),
      .opamp_one_en(en[0]), .dac_one_output(sv[1]), .dac_one_en(en[1]),
      .comparator_one_output(sv[2]), .comparator_one_en(en[2]),
      .comparator_two_output(sv[3]), .comparator_two_en(en[3]),
      .clock_out_signal(sv[4]), .clock_out_en(en[4]), .port_a_pins_in(pin_in),
      .port_a_pins_out(p_out), .port_a_pins_oe(p_oe), .analog_in_en(a_en),
      .port_a_pins_rd(p_rd), .pin6_src(src));
   pamux_far i_pamux_far (.ref_clk, .pins_out(p_out), .pins_oe(p_oe),
      .src_val(sv), .pins_in(pin_in));
   initial forever #50 ref_clk = ~ref_clk;
   // =========================================
   // checking
   task chk(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : chk
   task end_sim;
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : end_sim
   // expectation taken 10 ns after the falling edge, once the sources have moved
   task step(input logic [4:0] e, input logic [7:0] l, d, a);
      @(negedge ref_clk);
      {en, lat, drv, an} = {e, l, d, a};
      #10;
      e_out = l;
      e_oe = d | {1'b0, e[4] | e[3], e[3], e[2], 1'b0, e[1], e[0], 1'b0};
      if (e[0]) e_out[1] = sv[0];
      if (e[1]) e_out[2] = sv[1];
      if (e[2]) e_out[4] = sv[2];
      if (e[3]) {e_out[5], e_out[6]} = {2{sv[3]}};
      if (e[4]) e_out[6] = sv[4];
      e_src = e[4] ? PAMUX_SRC_CKOUT : e[3] ? PAMUX_SRC_CMP2 : PAMUX_SRC_LATCH;
      e_rd = pin_in & ~a;
      @(posedge ref_clk);
      #10;
      chk(p_out, e_out);
      chk(p_oe, e_oe);
      chk({5'h00, src}, {5'h00, e_src});
      chk(a_en, a);
      chk(p_rd, e_rd);
   endtask : step
   // =========================================
   // scenarios
   task t_latch;
      step(5'h00, 8'ha5, 8'h3c, 8'h00);
      step(5'h00, 8'h5a, 8'hc3, 8'h00);
   endtask : t_latch
   task t_each;
      for (int i = 0; i < 5; i++) step(5'h01 << i, 8'hff, 8'h00, 8'h00);
   endtask : t_each
   task t_pin6;
      // both, clock out alone, comparator two alone, twice over
      for (int i = 0; i < 6; i++) begin
         step(5'h18 - 5'(5'h08 * (i % 3)), 8'h40, 8'h00, 8'h00);
      end
   endtask : t_pin6
   // reset in mid-run with every source enabled, then resume
   task t_reset;
      step(5'h1f, 8'hff, 8'hff, 8'hff);
      @(negedge ref_clk);
      rst = 1'b1;
      @(posedge ref_clk);
      #10;
      chk(p_out, PAMUX_RST_OUT);
      chk(p_oe, PAMUX_RST_OE);
      chk(a_en, PAMUX_RST_AN);
      chk(p_rd, 8'h00);
      chk({5'h00, src}, {5'h00, PAMUX_SRC_LATCH});
      @(negedge ref_clk);
      rst = 1'b0;
      step(5'h10, 8'h00, 8'h00, 8'h00);
   endtask : t_reset
   task t_analog;
      for (int i = 0; i < 3; i++) step(5'h1f, 8'h00, 8'hff, 8'hff);
      step(5'h00, 8'h0f, 8'h0f, 8'h55);
   endtask : t_analog
   initial begin
      #20000;
      n_fail++;
      end_sim;
   end
   initial begin
      repeat (12) @(negedge ref_clk);
      chk(p_out | p_oe | a_en, PAMUX_RST_OUT | PAMUX_RST_OE | PAMUX_RST_AN);
      chk(p_rd, 8'h00);
      chk({5'h00, src}, {5'h00, PAMUX_SRC_LATCH});
      rst = 1'b0;
      t_latch;
      t_each;
      t_pin6;
      t_analog;
      t_reset;
      end_sim;
   end
endmodule : pamux_tb
